// ===== dv/cpu_exception_vectoring_monitor.sv
module cpu_exception_vectoring_monitor
  import exc_vec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic insn_boundary,
  input wire logic flow_change,
  input wire flow_addr_t flow_target,
  input wire flow_addr_t insn_start,
  input wire logic async_req,
  input wire logic sync_req,
  input wire logic stack_done,
  input wire logic fetch_ack,
  input wire logic [15:0] fetch_data,
  input wire exc_state_t state,
  input wire fetch_req_t fetch,
  input wire flow_addr_t program_addr,
  input wire flow_addr_t return_addr,
  input wire logic pipe_flush,
  input wire logic [7:0] vector_number,
  input wire logic clear_program_bank
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic exc_go;
  assign exc_go = sync_req || async_req && insn_boundary;
  a_flow_new_stream: assert property (state == ST_RUN && flow_change && !exc_go
    |=> program_addr == $past(flow_target) ##1 pipe_flush) else $error("flow target not loaded");
  a_sync_plus_two: assert property (state == ST_RUN && sync_req |=> state == ST_STACK &&
    return_addr == 20'($past(insn_start) + PC_AHEAD + SYNC_ADJ)) else $error("sync return wrong");
  a_async_at_boundary: assert property (state == ST_RUN && exc_go && !sync_req |=>
    state == ST_STACK && return_addr == 20'($past(insn_start) + PC_AHEAD)) else $error("async return wrong");
  a_bank_clear_stack: assert property (state == ST_STACK && stack_done |=>
    clear_program_bank && state == ST_VECTOR) else $error("bank not cleared");
  a_vector_addr_map: assert property (state == ST_VECTOR && fetch.req |->
    fetch.addr == {11'h000, vector_number, 1'b0} && !fetch.program_space) else $error("vector address wrong");
  a_vector_to_pc: assert property (state == ST_VECTOR && fetch.req && fetch_ack |=>
    program_addr == {BANK0, $past(fetch_data)} ##1 pipe_flush) else $error("vector not loaded");
  a_reset_word_space: assert property (state == ST_RESET && fetch.req |->
    fetch.program_space && fetch.addr[19:3] == 17'h00000) else $error("reset fetch outside table");
  a_reset_word_order: assert property (state == ST_RESET && fetch.req && fetch_ack |=>
    !fetch.req || fetch.addr == $past(fetch.addr) + 20'h00002) else $error("reset words out of order");
  c_sync: cover property (state == ST_RUN && sync_req);
  c_async: cover property (state == ST_RUN && async_req && insn_boundary);
  c_flow: cover property (state == ST_RUN && flow_change);
endmodule

bind cpu_exception_vectoring cpu_exception_vectoring_monitor mon_u (
  .clk, .rst_b, .insn_boundary, .flow_change, .flow_target, .insn_start, .async_req, .sync_req,
  .stack_done, .fetch_ack, .fetch_data, .state, .fetch, .program_addr, .return_addr, .pipe_flush,
  .vector_number, .clear_program_bank);

// ===== dv/cpu_exception_vectoring_tb_top.sv
module cpu_exception_vectoring_tb_top;
  import exc_vec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, insn_boundary = 1'b0, flow_change = 1'b0, flow_temporary = 1'b0, slow = 1'b1;
  logic async_req = 1'b0, ext_vector_valid = 1'b0, sync_req = 1'b0, stack_done = 1'b0, bus_start = 1'b0;
  logic bus_wait = 1'b0, bus_is_operand = 1'b0, int_op = 1'b0, fetch_ack, return_valid, pipe_flush;
  logic clear_program_bank, bus_done, insn_done;
  logic [7:0] ext_vector = 8'h00, int_op_pairs = 8'h00, vector_number, bus_periods;
  logic [2:0] irq_level = 3'h0;
  logic [15:0] fetch_data, program_access_periods, operand_access_periods, internal_operation_periods;
  logic [15:0] total_clock_periods;
  exc_src_t async_src = SRC_NONE, sync_src = SRC_NONE;
  flow_addr_t flow_target = 20'h00000, insn_start = 20'h12340, program_addr, return_addr;
  exc_state_t state;
  fetch_req_t fetch;
  reset_ctx_t reset_ctx;
  int errors = 0, comparisons = 0;
  cpu_exception_vectoring dut_u (.*);
  vec_mem_model mem_u (.clk, .fetch, .slow, .fetch_ack, .fetch_data);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_st(input exc_state_t s);
    for (int i = 0; i < 40 && state !== s; i++) tick(1);
    chk(20'(state), 20'(s), "state");
  endtask
  task automatic wait_bus;
    for (int i = 0; i < 40 && bus_done !== 1'b1; i++) tick(1);
    chk(20'(bus_done), 20'h1, "bus done");
  endtask
  task automatic t_reset;
    rst_b = 1'b1;
    tick(1);
    chk(20'(fetch.req), 20'h1, "first fetch");
    chk(fetch.addr, 20'h00000, "first word");
    wait_st(ST_RUN);
    chk(20'(reset_ctx[59:48]), 20'h005AA, "extensions");
    chk(20'(reset_ctx.program_counter), 20'h05A58, "pc");
    chk(20'(reset_ctx.stack_pointer), 20'h05A5E, "sp");
    chk(20'(reset_ctx.direct_page_index), 20'h05A5C, "iz");
    $display("reset test done");
  endtask
  task automatic t_flow;
    flow_target = 20'h28000;
    flow_change = 1'b1;
    flow_temporary = 1'b1;
    tick(1);
    flow_change = 1'b0;
    chk(program_addr, 20'h28000, "new stream");
    tick(1);
    chk(20'(pipe_flush), 20'h1, "discard");
    chk(20'(return_valid), 20'h1, "return kept");
    wait_st(ST_RUN);
    $display("flow test done");
  endtask
  task automatic t_exc(input logic sync, input exc_src_t src, input logic [2:0] lvl, input logic ext,
                       input logic [7:0] vec);
    sync_src = src;
    async_src = src;
    irq_level = lvl;
    ext_vector_valid = ext;
    ext_vector = ext ? vec : 8'hC3;
    if (sync) sync_req = 1'b1;
    else begin
      async_req = 1'b1;
      tick(2);
      chk(20'(state), 20'(ST_RUN), "held off");
      insn_boundary = 1'b1;
    end
    tick(1);
    {sync_req, async_req, insn_boundary} = 3'h0;
    chk(20'(vector_number), 20'(vec), "vector");
    chk(return_addr, sync ? 20'h12348 : 20'h12346, "return");
    stack_done = 1'b1;
    tick(1);
    stack_done = 1'b0;
    chk(20'(clear_program_bank), 20'h1, "bank clear");
    chk({fetch.addr, fetch.program_space}, {11'h000, vec, 2'h0}, "vector fetch");
    wait_st(ST_FLUSH);
    chk(program_addr, {4'h0, {7'h00, vec, 1'b0} ^ 16'h5A5A}, "handler");
    wait_st(ST_RUN);
    $display("exception %h test done", vec);
  endtask
  task automatic t_timing;
    logic [7:0] n;
    bus_start = 1'b1;
    tick(1);
    bus_start = 1'b0;
    wait_bus();
    chk(20'(bus_periods), 20'h2, "short bus");
    tick(1);
    {bus_is_operand, bus_start, bus_wait} = 3'h7;
    tick(1);
    bus_start = 1'b0;
    tick(2);
    bus_wait = 1'b0;
    wait_bus();
    n = bus_periods;
    chk(20'(n > 8'h02), 20'h1, "stretched");
    int_op_pairs = 8'h03;
    int_op = 1'b1;
    tick(1);
    int_op = 1'b0;
    tick(8);
    chk(20'(internal_operation_periods), 20'h6, "internal");
    chk(20'(operand_access_periods), 20'(n), "operand");
    chk(20'(program_access_periods), 20'h2, "program");
    chk(20'(total_clock_periods), 20'(n) + 20'h8, "total");
    insn_boundary = 1'b1;
    tick(1);
    insn_boundary = 1'b0;
    chk(20'(insn_done), 20'h1, "insn done");
    chk(20'(total_clock_periods), 20'(n) + 20'h8, "insn total");
    tick(1);
    chk(20'(total_clock_periods), 20'h0, "next insn");
    $display("timing test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tick(12);
    t_reset();
    slow = 1'b0;
    t_flow();
    t_timing();
    t_exc(1'b1, SRC_SWI, 3'h0, 1'b0, 8'h06);
    t_exc(1'b1, SRC_ILLEGAL, 3'h0, 1'b0, 8'h07);
    t_exc(1'b1, SRC_DIVZERO, 3'h0, 1'b0, 8'h08);
    t_exc(1'b0, SRC_BKPT, 3'h0, 1'b0, 8'h04);
    t_exc(1'b0, SRC_BUSERR, 3'h0, 1'b0, 8'h05);
    t_exc(1'b0, SRC_INTR, 3'h0, 1'b0, 8'h18);
    for (int l = 1; l < 8; l++) t_exc(1'b0, SRC_INTR, 3'(l), 1'b0, 8'h10 + 8'(l));
    t_exc(1'b0, SRC_INTR, 3'h2, 1'b1, 8'h38);
    t_exc(1'b0, SRC_INTR, 3'h5, 1'b1, 8'hFF);
    t_exc(1'b1, SRC_NONE, 3'h0, 1'b0, 8'h0F);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule

// ===== dv/vec_mem_model.sv
module vec_mem_model
  import exc_vec_pkg::*;
(
  input wire logic clk,
  input wire fetch_req_t fetch,
  input wire logic slow,
  output logic fetch_ack,
  output logic [15:0] fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lag = 2'h0;
  initial begin
    fetch_ack = 1'b0;
    fetch_data = 16'h0000;
  end
  always @(posedge clk) begin
    if (fetch.req && !fetch_ack && lag == (slow ? 2'h2 : 2'h0)) begin
      fetch_ack <= 1'b1;
      fetch_data <= fetch.addr[15:0] ^ 16'h5A5A;
      lag <= 2'h0;
    end else begin
      // data is not held once the answer is gone
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      lag <= (fetch.req && !fetch_ack) ? lag + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== src/cpu_exception_vectoring.sv
// Operation
// (RULE_01) on a flow change the program counter points six bytes past instruction start
// (RULE_02) load new stream address, then discard stage A and B words
// (RULE_03) a temporary flow change saves a return address
// (RULE_04) bus cycles take at least two whole clock periods, stretched by wait
// (RULE_05) internal operations take multiples of two clock periods
// (RULE_06) one instruction at a time; stream time is the sum
// (RULE_07) total periods equal program plus operand plus internal periods
// (RULE_08) vector table lies in the lowest 512 bytes of bank 0
// (RULE_09) ordinary vectors are one data word; reset is four program words
// (RULE_10) 56 fixed or reserved vectors, user vectors 38 to FF
// (RULE_11) vector address is the 8-bit vector number shifted left once
// (RULE_12) external devices supply some vector numbers, the core the rest
// (RULE_13) reset loads bank extensions from word 0000, program counter from 0002
// (RULE_14) reset loads stack pointer from 0004, direct page index from 0006
// (RULE_15) fixed numbers for breakpoint, bus error, swi, illegal, divide, uninit, spurious
// (RULE_16) autovectors for levels 1 to 7 are numbers 11 to 17
// (RULE_17) after stacking, clear the program bank extension field
// (RULE_18) asynchronous exceptions start at the next instruction boundary
// (RULE_19) synchronous exceptions stack the program counter plus two
// (RULE_20) vector fetch address sits in bank 0, upper bits zero
// (RULE_21) reset vector words are fetched in ascending order before first instruction
module cpu_exception_vectoring
  import exc_vec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic insn_boundary,
  input wire logic flow_change,
  input wire logic flow_temporary,
  input wire flow_addr_t flow_target,
  input wire flow_addr_t insn_start,
  input wire logic async_req,
  input wire exc_src_t async_src,
  input wire logic ext_vector_valid,
  input wire logic [7:0] ext_vector,
  input wire logic [2:0] irq_level,
  input wire logic sync_req,
  input wire exc_src_t sync_src,
  input wire logic stack_done,
  input wire logic bus_start,
  input wire logic bus_wait,
  input wire logic bus_is_operand,
  input wire logic int_op,
  input wire logic [7:0] int_op_pairs,
  input wire logic fetch_ack,
  input wire logic [15:0] fetch_data,
  output exc_state_t state,
  output fetch_req_t fetch,
  output flow_addr_t program_addr,
  output flow_addr_t return_addr,
  output logic return_valid,
  output logic pipe_flush,
  output logic [7:0] vector_number,
  output logic clear_program_bank,
  output reset_ctx_t reset_ctx,
  output logic bus_done,
  output logic [7:0] bus_periods,
  output logic [15:0] program_access_periods,
  output logic [15:0] operand_access_periods,
  output logic [15:0] internal_operation_periods,
  output logic [15:0] total_clock_periods,
  output logic insn_done
);

  typedef struct packed {
    exc_state_t st;
    logic [1:0] rst_word;
    logic fetch_req;
    logic [ADDR_W-1:0] fetch_addr;
    logic fetch_prog;
    flow_addr_t pc;
    flow_addr_t ret;
    logic ret_valid;
    logic flush;
    logic [7:0] vec;
    logic clr_pk;
    reset_ctx_t rctx;
    logic bus_active;
    logic bus_is_op;
    logic [7:0] bus_cnt;
    logic bus_done;
    logic [7:0] bus_len;
    logic [7:0] int_cnt;
    logic [15:0] cl_p;
    logic [15:0] cl_o;
    logic [15:0] cl_i;
    logic [15:0] cl_t;
    logic done;
  } core_t;

  core_t cur;
  core_t next_cur;

  // maps a core-generated exception source to its fixed vector number
  function automatic logic [7:0] fixed_vector(input exc_src_t src, input logic [2:0] lvl);
    logic [7:0] v;
    v = VEC_UNINIT;
    case (src)
      // (RULE_15) fixed vector numbers
      SRC_BKPT: v = VEC_BKPT;
      SRC_BUSERR: v = VEC_BUSERR;
      SRC_SWI: v = VEC_SWI;
      SRC_ILLEGAL: v = VEC_ILLEGAL;
      SRC_DIVZERO: v = VEC_DIVZERO;
      SRC_SPURIOUS: v = VEC_SPURIOUS;
      // (RULE_16) level autovectors
      SRC_INTR: v = (lvl == 3'h0) ? VEC_SPURIOUS : (VEC_AUTO_BASE | {5'h00, lvl});
      default: v = VEC_UNINIT;
    endcase
    return v;
  endfunction

  // (RULE_11) doubled number, always inside the 512-byte table
  // (RULE_10) user numbers 38 to FF land at 0070 to 01FE
  function automatic logic [ADDR_W-1:0] vector_addr(input logic [7:0] num);
    // (RULE_08) (RULE_20) bank 0, upper bits zero
    return {BANK0, 7'h00, num, 1'b0};
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.flush = 1'b0;
    next_cur.clr_pk = 1'b0;
    next_cur.bus_done = 1'b0;
    next_cur.done = 1'b0;
    case (cur.st)
      ST_RESET: begin
        // (RULE_09) (RULE_21) four program-space words, ascending
        next_cur.fetch_req = 1'b1;
        next_cur.fetch_prog = 1'b1;
        next_cur.fetch_addr = {BANK0, 1'b0, RST_WORD_EXT[14:0] | {12'h000, cur.rst_word, 1'b0}};
        if (cur.fetch_req && fetch_ack) begin
          case (cur.rst_word)
            // (RULE_13) extension word, then program counter
            2'h0: begin
              next_cur.rctx.z_index_bank_extension = fetch_data[15:12];
              next_cur.rctx.stack_bank_extension = fetch_data[11:8];
              next_cur.rctx.program_bank_extension = fetch_data[3:0];
              next_cur.pc.program_bank_extension = fetch_data[3:0];
            end
            2'h1: begin
              next_cur.rctx.program_counter = fetch_data;
              next_cur.pc.program_counter = fetch_data;
            end
            // (RULE_14) stack pointer and direct page
            2'h2: next_cur.rctx.stack_pointer = fetch_data;
            default: next_cur.rctx.direct_page_index = fetch_data;
          endcase
          if (cur.rst_word == RST_WORDS_LAST) begin
            next_cur.fetch_req = 1'b0;
            next_cur.st = ST_FLUSH;
          end else begin
            next_cur.rst_word = cur.rst_word + 2'h1;
            next_cur.fetch_addr = {BANK0, 1'b0, RST_WORD_EXT[14:0] | {12'h000, cur.rst_word + 2'h1, 1'b0}};
          end
        end
      end
      ST_RUN: begin
        if (sync_req) begin
          // (RULE_19) resume after the faulting instruction
          next_cur.ret = {insn_start.program_bank_extension,
                          insn_start.program_counter + PC_AHEAD + SYNC_ADJ};
          next_cur.ret_valid = 1'b1;
          // (RULE_12) core supplies the number
          next_cur.vec = fixed_vector(sync_src, irq_level);
          next_cur.st = ST_STACK;
        end else if (async_req && insn_boundary) begin
          // (RULE_18) taken on an instruction boundary
          next_cur.ret = {insn_start.program_bank_extension, insn_start.program_counter + PC_AHEAD};
          next_cur.ret_valid = 1'b1;
          // (RULE_12) external number when offered
          next_cur.vec = ext_vector_valid ? ext_vector : fixed_vector(async_src, irq_level);
          next_cur.st = ST_STACK;
        end else if (flow_change) begin
          // (RULE_01) pc ahead of instruction by six
          if (flow_temporary) begin
            // (RULE_03) keep the return point
            next_cur.ret = {insn_start.program_bank_extension, insn_start.program_counter + PC_AHEAD};
            next_cur.ret_valid = 1'b1;
          end
          // (RULE_02) load target then flush
          next_cur.pc = flow_target;
          next_cur.st = ST_FLUSH;
        end
      end
      ST_STACK: begin
        if (stack_done) begin
          // (RULE_17) program bank cleared after stacking
          next_cur.clr_pk = 1'b1;
          next_cur.pc.program_bank_extension = 4'h0;
          next_cur.fetch_req = 1'b1;
          next_cur.fetch_prog = 1'b0;
          next_cur.fetch_addr = vector_addr(cur.vec);
          next_cur.st = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        // (RULE_09) one data-space word
        if (fetch_ack) begin
          next_cur.fetch_req = 1'b0;
          next_cur.pc = {4'h0, fetch_data};
          next_cur.st = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // (RULE_02) stage A and B discarded
        next_cur.flush = 1'b1;
        next_cur.st = ST_RUN;
      end
      default: next_cur.st = ST_RESET;
    endcase

    // (RULE_04) two periods minimum, one more per wait period from the second period on
    if (cur.bus_active) begin
      next_cur.bus_cnt = cur.bus_cnt + 8'h01;
      if (cur.bus_cnt + 8'h01 >= MIN_BUS_PERIODS && !bus_wait) begin
        next_cur.bus_active = 1'b0;
        next_cur.bus_done = 1'b1;
        next_cur.bus_len = cur.bus_cnt + 8'h01;
        // (RULE_07) periods split by access kind
        if (cur.bus_is_op) begin
          next_cur.cl_o = cur.cl_o + {8'h00, cur.bus_cnt + 8'h01};
        end else begin
          next_cur.cl_p = cur.cl_p + {8'h00, cur.bus_cnt + 8'h01};
        end
      end
    end else if (bus_start) begin
      next_cur.bus_active = 1'b1;
      next_cur.bus_is_op = bus_is_operand;
      next_cur.bus_cnt = 8'h00;
    end

    // (RULE_05) internal ops counted in pairs of periods
    if (cur.int_cnt != 8'h00) begin
      next_cur.int_cnt = cur.int_cnt - 8'h01;
      next_cur.cl_i = cur.cl_i + 16'h0001;
    end else if (int_op && int_op_pairs != 8'h00) begin
      next_cur.int_cnt = 8'(int_op_pairs * INT_OP_QUANTUM - 8'h01);
      next_cur.cl_i = cur.cl_i + 16'h0001;
    end

    // (RULE_07) total is the sum of the three parts
    next_cur.cl_t = next_cur.cl_p + next_cur.cl_o + next_cur.cl_i;

    // (RULE_06) one instruction at a time; counts restart at a boundary seen in run with no bus cycle or internal op pending
    if (insn_boundary && cur.st == ST_RUN && !cur.bus_active && cur.int_cnt == 8'h00) begin
      next_cur.done = 1'b1;
      next_cur.cl_p = 16'h0000;
      next_cur.cl_o = 16'h0000;
      next_cur.cl_i = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign state = cur.st;
  assign fetch = '{req: cur.fetch_req, addr: cur.fetch_addr, program_space: cur.fetch_prog};
  assign program_addr = cur.pc;
  assign return_addr = cur.ret;
  assign return_valid = cur.ret_valid;
  assign pipe_flush = cur.flush;
  assign vector_number = cur.vec;
  assign clear_program_bank = cur.clr_pk;
  assign reset_ctx = cur.rctx;
  assign bus_done = cur.bus_done;
  assign bus_periods = cur.bus_len;
  assign program_access_periods = cur.cl_p;
  assign operand_access_periods = cur.cl_o;
  assign internal_operation_periods = cur.cl_i;
  assign total_clock_periods = cur.cl_t;
  assign insn_done = cur.done;

endmodule

// ===== src/exc_vec_pkg.sv
package exc_vec_pkg;
  localparam int ADDR_W = 20;
  localparam logic [3:0] BANK0 = 4'h0;
  localparam logic [15:0] PC_AHEAD = 16'h0006;
  localparam logic [15:0] SYNC_ADJ = 16'h0002;
  localparam logic [15:0] RST_WORD_EXT = 16'h0000;
  localparam logic [15:0] RST_WORD_PC = 16'h0002;
  localparam logic [15:0] RST_WORD_SP = 16'h0004;
  localparam logic [15:0] RST_WORD_IZ = 16'h0006;
  localparam logic [15:0] TABLE_BYTES = 16'h0200;
  localparam logic [7:0] VEC_BKPT = 8'h04;
  localparam logic [7:0] VEC_BUSERR = 8'h05;
  localparam logic [7:0] VEC_SWI = 8'h06;
  localparam logic [7:0] VEC_ILLEGAL = 8'h07;
  localparam logic [7:0] VEC_DIVZERO = 8'h08;
  localparam logic [7:0] VEC_UNINIT = 8'h0F;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h10;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_USER_FIRST = 8'h38;
  localparam logic [7:0] MIN_BUS_PERIODS = 8'h02;
  localparam logic [7:0] INT_OP_QUANTUM = 8'h02;
  localparam logic [1:0] RST_WORDS_LAST = 2'h3;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_BKPT = 3'h1,
    SRC_BUSERR = 3'h2,
    SRC_SWI = 3'h3,
    SRC_ILLEGAL = 3'h4,
    SRC_DIVZERO = 3'h5,
    SRC_INTR = 3'h6,
    SRC_SPURIOUS = 3'h7
  } exc_src_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN = 3'h1,
    ST_STACK = 3'h2,
    ST_VECTOR = 3'h3,
    ST_FLUSH = 3'h4
  } exc_state_t;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
    logic program_space;
  } fetch_req_t;

  typedef struct packed {
    logic [3:0] program_bank_extension;
    logic [15:0] program_counter;
  } flow_addr_t;

  typedef struct packed {
    logic [3:0] z_index_bank_extension;
    logic [3:0] stack_bank_extension;
    logic [3:0] program_bank_extension;
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [15:0] direct_page_index;
  } reset_ctx_t;
endpackage
